/* File: include/socb_pkg.sv */
// Package for the sensor option configuration bank.
// Assumes a 32-bit AXI4-Lite register bus and a single 125 MHz clock.
package socb_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [3:0] SOCB_OFF_BYTE_ZERO = 4'h0;
    localparam logic [3:0] SOCB_OFF_BYTE_ONE = 4'h4;
    localparam logic [3:0] SOCB_OFF_BYTE_TWO = 4'h8;
    localparam logic [3:0] SOCB_OFF_STATUS = 4'hC;
    localparam logic [7:0] SOCB_BYTE_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int SOCB_B2_OUT_TYPE = 5;
    localparam int SOCB_B2_RATIO = 4;
    localparam int SOCB_B2_GAIN_LO = 1;
    localparam int SOCB_B1_STREAM = 7;
    localparam int SOCB_B1_POWER_LO = 5;
    localparam int SOCB_B1_FREEZE_LO = 3;
    localparam int SOCB_B1_RECAL = 2;
    localparam int SOCB_B1_DUAL = 0;
    localparam int SOCB_B0_TOUCH_LO = 5;
    localparam int SOCB_B0_NEAR_LO = 3;
    localparam int SOCB_B0_POLARITY = 1;
    localparam int SOCB_B0_CTRL_TYPE = 0;
    // Reserved bits are forced to zero in what is stored.
    localparam logic [7:0] SOCB_B2_MASK = 8'h3E;
    localparam logic [7:0] SOCB_B1_MASK = 8'hFD;
    localparam logic [7:0] SOCB_B0_MASK = 8'hFB;

    // ------------------------------------------------------------------
    // AXI responses
    // ------------------------------------------------------------------
    localparam logic [1:0] SOCB_RESP_OKAY = 2'h0;
    localparam logic [1:0] SOCB_RESP_SLVERR = 2'h2;
    localparam logic [1:0] SOCB_RESP_DECERR = 2'h3;

    // ------------------------------------------------------------------
    // Timing, in their own units, and derived cycle counts
    // ------------------------------------------------------------------
    localparam int SOCB_CLK_MHZ = 125;
    localparam longint SOCB_FREEZE_18_S = 18;
    localparam longint SOCB_FREEZE_60_S = 60;
    localparam longint SOCB_FREEZE_3_S = 3;
    localparam longint SOCB_RECAL_250_MS = 250;
    localparam longint SOCB_RECAL_1_S = 1;
    localparam longint SOCB_CYC_PER_S = 64'(SOCB_CLK_MHZ) * 1000000;
    localparam longint SOCB_FREEZE_18_CYC = SOCB_FREEZE_18_S * SOCB_CYC_PER_S;
    localparam longint SOCB_FREEZE_60_CYC = SOCB_FREEZE_60_S * SOCB_CYC_PER_S;
    localparam longint SOCB_FREEZE_3_CYC = SOCB_FREEZE_3_S * SOCB_CYC_PER_S;
    localparam longint SOCB_RECAL_250_CYC =
        SOCB_RECAL_250_MS * SOCB_CYC_PER_S / 1000;
    localparam longint SOCB_RECAL_1_CYC = SOCB_RECAL_1_S * SOCB_CYC_PER_S;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        SOCB_POWER_NORMAL = 4'h1,
        SOCB_POWER_LOW1 = 4'h2,
        SOCB_POWER_LOW2 = 4'h4,
        SOCB_POWER_LOW3 = 4'h8
    } socb_power_t;

    typedef enum logic [2:0] {
        SOCB_MODE_CONTROL = 3'h1,
        SOCB_MODE_DUAL = 3'h2,
        SOCB_MODE_STREAM = 3'h4
    } socb_mode_t;

    // Decoded settings handed to the acquisition logic.
    typedef struct packed {
        socb_mode_t mode;
        logic control_uses_touch;
        logic release_is_7_8;
        logic [9:0] gain_target;
        socb_power_t power;
        logic [39:0] freeze_expiry_time;
        logic freeze_never_expires;
        logic [27:0] touch_recal_delay;
        logic shared_pin_is_output;
        logic [9:0] touch_level_select;
        logic [5:0] near_level_select;
        logic out_active_high;
        logic polarity_applies;
        logic detect_out_enabled;
        logic ctrl_freezes_reference;
    } socb_settings_t;

endpackage : socb_pkg

/* File: hw/socb_bank.sv */
// Option configuration bank with AXI4-Lite access and decoded settings.
// Assumes one clock, a synchronous active-low reset, and a master that
// keeps at most one write and one read outstanding.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Each option byte programs once, then stays fixed until reset clears it.
// - Blank part reads zero in all three bytes.
// - Third byte bit 5 picks touch or proximity.
// - Third byte bit 4 picks release ratio.
// - Third byte bits 3:1 pick gain target.
// - Second byte bit 7 enables data streaming.
// - Second byte bits 6:5 pick power level.
// - Second byte bits 4:3 pick freeze timeout.
// - Second byte bit 2 picks recalibration delay.
// - Second byte bit 0 configures shared pin.
// - First byte bits 7:5 pick touch threshold.
// - First byte bits 4:3 pick proximity threshold.
// - Polarity applies only while streaming disabled.
// - First byte bit 0 picks control function.
// - Streaming takes over the detection output pin.
module socb_bank
    import socb_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output socb_settings_t settings,
    output logic settings_valid
);

    // ------------------------------------------------------------------
    // Storage and decode tables
    // ------------------------------------------------------------------
    logic [7:0] byte_zero_reg, byte_zero_next;
    logic [7:0] byte_one_reg, byte_one_next;
    logic [7:0] byte_two_reg, byte_two_next;
    logic [2:0] burnt_reg, burnt_next;
    socb_settings_t settings_reg, settings_next;
    logic valid_reg, valid_next;

    function automatic logic [9:0] gain_of(input logic [2:0] code);
        case (code)
            3'h0: gain_of = 10'd200;
            3'h1: gain_of = 10'd250;
            3'h2: gain_of = 10'd300;
            3'h3: gain_of = 10'd350;
            3'h4: gain_of = 10'd400;
            3'h5: gain_of = 10'd550;
            3'h6: gain_of = 10'd700;
            default: gain_of = 10'd850;
        endcase
    endfunction

    function automatic logic [9:0] touch_of(input logic [2:0] code);
        case (code)
            3'h0: touch_of = 10'd40;
            3'h1: touch_of = 10'd60;
            3'h2: touch_of = 10'd100;
            3'h3: touch_of = 10'd200;
            3'h4: touch_of = 10'd360;
            3'h5: touch_of = 10'd500;
            3'h6: touch_of = 10'd700;
            default: touch_of = 10'd900;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    logic aw_held_reg, aw_held_next;
    logic [3:0] aw_addr_reg, aw_addr_next;
    logic w_held_reg, w_held_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;

    // Address and data are caught separately in either order; the write
    // lands once both are held and no response is pending.
    always_comb begin
        logic do_write;
        logic [7:0] val;
        do_write = 1'b0;
        val = 8'h00;
        aw_held_next = aw_held_reg;
        aw_addr_next = aw_addr_reg;
        w_held_next = w_held_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        byte_zero_next = byte_zero_reg;
        byte_one_next = byte_one_reg;
        byte_two_next = byte_two_reg;
        burnt_next = burnt_reg;
        if (s_axi_awvalid && awready_reg) begin
            aw_held_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_reg) begin
            w_held_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (aw_held_reg && w_held_reg && !bvalid_reg) begin
            do_write = 1'b1;
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = SOCB_RESP_OKAY;
        end
        if (do_write) begin
            case (aw_addr_reg)
                SOCB_OFF_BYTE_ZERO: begin
                    val = w_data_reg[7:0] & SOCB_B0_MASK;
                    if (burnt_reg[0] || !w_strb_reg[0]) begin
                        bresp_next = SOCB_RESP_SLVERR;
                    end else begin
                        byte_zero_next = val;
                        burnt_next[0] = 1'b1;
                    end
                end
                SOCB_OFF_BYTE_ONE: begin
                    val = w_data_reg[7:0] & SOCB_B1_MASK;
                    if (burnt_reg[1] || !w_strb_reg[0]) begin
                        bresp_next = SOCB_RESP_SLVERR;
                    end else begin
                        byte_one_next = val;
                        burnt_next[1] = 1'b1;
                    end
                end
                SOCB_OFF_BYTE_TWO: begin
                    val = w_data_reg[7:0] & SOCB_B2_MASK;
                    if (burnt_reg[2] || !w_strb_reg[0]) begin
                        bresp_next = SOCB_RESP_SLVERR;
                    end else begin
                        byte_two_next = val;
                        burnt_next[2] = 1'b1;
                    end
                end
                SOCB_OFF_STATUS: bresp_next = SOCB_RESP_SLVERR;
                default: bresp_next = SOCB_RESP_DECERR;
            endcase
        end
        awready_next = !aw_held_next;
        wready_next = !w_held_next;
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic arready_reg, arready_next;

    // One read at a time; arready drops while the answer is waiting.
    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        if (s_axi_arvalid && arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next = SOCB_RESP_OKAY;
            rdata_next = 32'h0000_0000;
            case (s_axi_araddr)
                SOCB_OFF_BYTE_ZERO: rdata_next[7:0] = byte_zero_reg;
                SOCB_OFF_BYTE_ONE: rdata_next[7:0] = byte_one_reg;
                SOCB_OFF_BYTE_TWO: rdata_next[7:0] = byte_two_reg;
                SOCB_OFF_STATUS: rdata_next[3:0] = {valid_reg, burnt_reg};
                default: rresp_next = SOCB_RESP_DECERR;
            endcase
        end
        arready_next = !rvalid_next;
    end

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    // Decoded settings are a registered copy, so acquisition sees only
    // whole, settled values one cycle after any byte is programmed.
    always_comb begin
        logic [1:0] pw;
        logic [1:0] fr;
        pw = byte_one_reg[SOCB_B1_POWER_LO +: 2];
        fr = byte_one_reg[SOCB_B1_FREEZE_LO +: 2];
        settings_next = settings_reg;
        if (byte_one_reg[SOCB_B1_STREAM]) begin
            settings_next.mode = SOCB_MODE_STREAM;
        end else if (byte_one_reg[SOCB_B1_DUAL]) begin
            settings_next.mode = SOCB_MODE_DUAL;
        end else begin
            settings_next.mode = SOCB_MODE_CONTROL;
        end
        settings_next.control_uses_touch =
            byte_two_reg[SOCB_B2_OUT_TYPE];
        settings_next.release_is_7_8 = byte_two_reg[SOCB_B2_RATIO];
        settings_next.gain_target =
            gain_of(byte_two_reg[SOCB_B2_GAIN_LO +: 3]);
        case (pw)
            2'h0: settings_next.power = SOCB_POWER_NORMAL;
            2'h1: settings_next.power = SOCB_POWER_LOW1;
            2'h2: settings_next.power = SOCB_POWER_LOW2;
            default: settings_next.power = SOCB_POWER_LOW3;
        endcase
        settings_next.freeze_never_expires = (fr == 2'h0);
        case (fr)
            2'h1: settings_next.freeze_expiry_time =
                40'(SOCB_FREEZE_18_CYC);
            2'h2: settings_next.freeze_expiry_time =
                40'(SOCB_FREEZE_60_CYC);
            2'h3: settings_next.freeze_expiry_time =
                40'(SOCB_FREEZE_3_CYC);
            default: settings_next.freeze_expiry_time = 40'h00_0000_0000;
        endcase
        settings_next.touch_recal_delay = byte_one_reg[SOCB_B1_RECAL] ?
            28'(SOCB_RECAL_1_CYC) : 28'(SOCB_RECAL_250_CYC);
        settings_next.shared_pin_is_output =
            byte_one_reg[SOCB_B1_DUAL];
        settings_next.touch_level_select =
            touch_of(byte_zero_reg[SOCB_B0_TOUCH_LO +: 3]);
        settings_next.near_level_select =
            6'd4 << byte_zero_reg[SOCB_B0_NEAR_LO +: 2];
        settings_next.polarity_applies =
            !byte_one_reg[SOCB_B1_STREAM];
        settings_next.out_active_high = byte_zero_reg[SOCB_B0_POLARITY] &&
            !byte_one_reg[SOCB_B1_STREAM];
        settings_next.detect_out_enabled =
            !byte_one_reg[SOCB_B1_STREAM];
        settings_next.ctrl_freezes_reference =
            byte_zero_reg[SOCB_B0_CTRL_TYPE];
        valid_next = 1'b1;
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            byte_zero_reg <= SOCB_BYTE_RESET;
            byte_one_reg <= SOCB_BYTE_RESET;
            byte_two_reg <= SOCB_BYTE_RESET;
            burnt_reg <= 3'h0;
            settings_reg <= '0;
            valid_reg <= 1'b0;
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= SOCB_RESP_OKAY;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= SOCB_RESP_OKAY;
            arready_reg <= 1'b0;
        end else begin
            byte_zero_reg <= byte_zero_next;
            byte_one_reg <= byte_one_next;
            byte_two_reg <= byte_two_next;
            burnt_reg <= burnt_next;
            settings_reg <= settings_next;
            valid_reg <= valid_next;
            aw_held_reg <= aw_held_next;
            aw_addr_reg <= aw_addr_next;
            w_held_reg <= w_held_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            arready_reg <= arready_next;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign settings = settings_reg;
    assign settings_valid = valid_reg;

endmodule // socb_bank

`default_nettype wire

/* File: tb/socb_bank_properties.sv */
// Concurrent checks on the option bank, bound to its top module.
// Assumes only the bank's own ports and its single clock domain.
`timescale 1ns/1ps
`default_nettype none
module socb_bank_props
    import socb_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire socb_settings_t settings,
    input wire logic settings_valid
);
    // ------------------------------------------------------------------
    // Bus timing and decoded settings
    // ------------------------------------------------------------------
    // One domain, so clock and reset are given once for all checks.
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_bresp_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write answer dropped early");
    a_rdata_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer dropped early");
    a_wr_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("no bvalid");
    a_rd_answer:
    assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2]
        s_axi_rvalid) else $error("no rvalid");
    // A change of settings must trace back to an accepted write.
    a_settle_write:
    assert property ($past(settings_valid) && settings != $past(settings)
        |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
        else $error("settings changed without a write");
    a_stream_owns:
    assert property (settings_valid |-> settings.detect_out_enabled ==
        (settings.mode != SOCB_MODE_STREAM) && settings.polarity_applies ==
        settings.detect_out_enabled && (settings.polarity_applies ||
        !settings.out_active_high)) else $error("stream output clash");
    a_gain_legal:
    assert property (settings_valid |-> settings.gain_target inside {10'h0C8,
        10'h0FA, 10'h12C, 10'h15E, 10'h190, 10'h226, 10'h2BC, 10'h352})
        else $error("gain target off table");
    a_touch_legal:
    assert property (settings_valid |-> settings.touch_level_select inside {
        10'h028, 10'h03C, 10'h064, 10'h0C8, 10'h168, 10'h1F4, 10'h2BC,
        10'h384}) else $error("touch level off table");
    a_near_legal:
    assert property (settings_valid |-> settings.near_level_select inside {
        6'h04, 6'h08, 6'h10, 6'h20}) else $error("near level off table");
    a_power_onehot:
    assert property (settings_valid |-> $onehot(settings.power))
        else $error("power not one-hot");
    a_freeze_legal:
    assert property (settings_valid && !settings.freeze_never_expires |->
        settings.freeze_expiry_time inside {SOCB_FREEZE_3_CYC,
        SOCB_FREEZE_18_CYC, SOCB_FREEZE_60_CYC}) else $error("bad freeze");
    a_recal_legal:
    assert property (settings_valid |-> settings.touch_recal_delay inside {
        SOCB_RECAL_250_CYC, SOCB_RECAL_1_CYC}) else $error("bad recal");
endmodule // socb_bank_props

bind socb_bank socb_bank_props socb_bank_props_inst (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .settings(settings), .settings_valid(settings_valid));
`default_nettype wire

/* File: tb/socb_bank_bench.sv */
// Self-checking bench for the option bank over AXI4-Lite.
// Assumes the bank alone, one 125 MHz clock and a reset per pass.
`timescale 1ns/1ps
`default_nettype none
module socb_bank_bench
    import socb_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, settings_valid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    socb_settings_t settings;
    int err_total = 0, check_count = 0, cyc_count = 0;
    logic [2:0] c;
    logic st;
    logic [7:0] b0, b1, b2;
    socb_mode_t em;
    logic [9:0] gain_tab [8] = '{10'h0C8, 10'h0FA, 10'h12C, 10'h15E,
        10'h190, 10'h226, 10'h2BC, 10'h352};
    logic [9:0] touch_tab [8] = '{10'h028, 10'h03C, 10'h064, 10'h0C8,
        10'h168, 10'h1F4, 10'h2BC, 10'h384};
    logic [5:0] near_tab [4] = '{6'h04, 6'h08, 6'h10, 6'h20};
    longint frz_tab [4] = '{64'h0, SOCB_FREEZE_18_CYC, SOCB_FREEZE_60_CYC,
        SOCB_FREEZE_3_CYC};

    socb_bank socb_bank_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .settings(settings),
        .settings_valid(settings_valid));

    // ------------------------------------------------------------------
    // Clock, watchdog and bus tasks
    // ------------------------------------------------------------------
    // Free-running 8 ns clock.
    initial begin
        forever #4 aclk = ~aclk;
    end

    // A hung handshake would stall forever, so cap the run length.
    always @(posedge aclk) begin
        cyc_count <= cyc_count + 1;
        if (cyc_count == 4000) begin
            err_total++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (err_total == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] seen,
        input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    // Each pass burns fresh bytes, so reset clears the programmed flags.
    task automatic reset_dut();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask

    // Upper data bits carry junk on purpose; only bits 7:0 count.
    task automatic wr(input logic [3:0] a, input logic [7:0] d,
        input logic [3:0] sb, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'hA5A5A5, d};
        s_axi_wstrb <= sb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", s_axi_bresp, er);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e,
        input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk("rdata", s_axi_rdata, {24'h0, e});
        chk("rresp", s_axi_rresp, er);
    endtask

    // ------------------------------------------------------------------
    // One pass per code: every table entry and every mode is visited
    // ------------------------------------------------------------------
    // Reserved bits are always set in what is written, to see them drop.
    initial begin
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            st = (c == 3'h7);
            b0 = {c, c[1:0], 1'b1, c[0], c[1]};
            b1 = {st, c[1:0], c[1:0], c[0], 1'b1, c[0]};
            b2 = {2'h3, c[0], c[1], c, 1'b1};
            em = st ? SOCB_MODE_STREAM
                : (c[0] ? SOCB_MODE_DUAL : SOCB_MODE_CONTROL);
            reset_dut();
            rd(SOCB_OFF_BYTE_ZERO, 8'h00, SOCB_RESP_OKAY);
            rd(SOCB_OFF_BYTE_ONE, 8'h00, SOCB_RESP_OKAY);
            rd(SOCB_OFF_BYTE_TWO, 8'h00, SOCB_RESP_OKAY);
            rd(SOCB_OFF_STATUS, 8'h08, SOCB_RESP_OKAY);
            wr(SOCB_OFF_BYTE_ZERO, b0, 4'hE, SOCB_RESP_SLVERR);
            wr(SOCB_OFF_BYTE_ZERO, b0, 4'h1, SOCB_RESP_OKAY);
            wr(SOCB_OFF_BYTE_ONE, b1, 4'hF, SOCB_RESP_OKAY);
            wr(SOCB_OFF_BYTE_TWO, b2, 4'h1, SOCB_RESP_OKAY);
            wr(SOCB_OFF_BYTE_ONE, ~b1, 4'h1, SOCB_RESP_SLVERR);
            wr(SOCB_OFF_STATUS, 8'hFF, 4'h1, SOCB_RESP_SLVERR);
            wr(4'h6, 8'hFF, 4'h1, SOCB_RESP_DECERR);
            rd(4'h6, 8'h00, SOCB_RESP_DECERR);
            rd(SOCB_OFF_BYTE_ZERO, b0 & SOCB_B0_MASK, SOCB_RESP_OKAY);
            rd(SOCB_OFF_BYTE_ONE, b1 & SOCB_B1_MASK, SOCB_RESP_OKAY);
            rd(SOCB_OFF_BYTE_TWO, b2 & SOCB_B2_MASK, SOCB_RESP_OKAY);
            rd(SOCB_OFF_STATUS, 8'h0F, SOCB_RESP_OKAY);
            repeat (2) @(posedge aclk);
            chk("mode", settings.mode, em);
            chk("out_type", settings.control_uses_touch, c[0]);
            chk("ratio", settings.release_is_7_8, c[1]);
            chk("gain", settings.gain_target, gain_tab[c]);
            chk("power", settings.power, 4'h1 << c[1:0]);
            chk("never", settings.freeze_never_expires, c[1:0] == 0);
            chk("freeze", settings.freeze_expiry_time, frz_tab[c[1:0]]);
            chk("recal", settings.touch_recal_delay,
                c[0] ? SOCB_RECAL_1_CYC : SOCB_RECAL_250_CYC);
            chk("pin", settings.shared_pin_is_output, c[0]);
            chk("touch", settings.touch_level_select, touch_tab[c]);
            chk("near", settings.near_level_select, near_tab[c[1:0]]);
            chk("active", settings.out_active_high, c[0] & !st);
            chk("applies", settings.polarity_applies, !st);
            chk("detect", settings.detect_out_enabled, !st);
            chk("ctrl", settings.ctrl_freezes_reference, c[1]);
            chk("valid", settings_valid, 1'b1);
        end
        end_sim();
    end
endmodule // socb_bank_bench
`default_nettype wire
